/* File: verilog/tpo_map.vh */
// Functional notes
// - Current pointer readable, low and high registers.
// - Current pointer follows loads and justifications.
// - Writable ten-bit forced pointer, resets to zero.
// - Pointer load makes forced pointer the current.
// - Force transient sends forced value in pointer.
// - Spare-bit field copied into every sent pointer.
// - Flag pattern sent on load or flag enable.
// - Trace register sent when port, buffer disabled.
// - Signal label resets 13h, sent when port off.
// - Spare status bits from register when selected.
// - Aux remote defect bit follows its control bit.
// - Remote defect is control bit OR input pin.
// - Source select or enable pin overrides defect bits.
// - Error count field sent, then cleared automatically.
// - Nonzero software count replaces derived B3 count.
// - Nonzero count on read means still pending.
// - User channel register sent when port disabled.
// - Pointer load bit clears itself once loaded.
// - Normal flag 0110 outside load frame or forcing.
// - Pointer above 782 sent, timing keeps last valid.
`ifndef TPO_MAP_VH
`define TPO_MAP_VH

`define TPO_IDX_CUR_LO      8'h43
`define TPO_IDX_CUR_HI      8'h44
`define TPO_IDX_FRC_LO      8'h45
`define TPO_IDX_FRC_HI      8'h46
`define TPO_IDX_TRACE       8'h47
`define TPO_IDX_LABEL       8'h48
`define TPO_IDX_STATUS      8'h49
`define TPO_IDX_USER        8'h4a
`define TPO_IDX_PTR_CTRL    8'h41
`define TPO_IDX_SRC_CTRL    8'h42

`define TPO_BIT_FTP         6
`define TPO_BIT_LOAD        4
`define TPO_BIT_FLAG_EN     3
`define TPO_BIT_DEC         2
`define TPO_BIT_INC         1
`define TPO_BIT_SRC_STATUS  0
`define TPO_BIT_SRC_TRACE   1

`define TPO_RST_FRC_HI      8'h90
`define TPO_RST_LABEL       8'h13
`define TPO_FLAG_NORMAL     4'h6
`define TPO_PTR_MAX         10'h30e

`define TPO_SEL_J1          2'h0
`define TPO_SEL_C2          2'h1
`define TPO_SEL_G1          2'h2
`define TPO_SEL_F2          2'h3

`endif

/* File: verilog/tpo_regs.v */
`timescale 1ns/1ps
`include "tpo_map.vh"

module tpo_regs (
   input  wire        sys_clk_in,
   input  wire        reset_in,
   input  wire        hsel_in,
   input  wire [31:0] haddr_in,
   input  wire [1:0]  htrans_in,
   input  wire        hwrite_in,
   input  wire [2:0]  hsize_in,
   input  wire [31:0] hwdata_in,
   input  wire        hready_in,
   output wire [31:0] hrdata_out,
   output wire        hreadyout_out,
   output wire        hresp_out,
   input  wire        frame_start_in,
   input  wire        poh_bit_strobe_in,
   input  wire [1:0]  poh_byte_sel_in,
   input  wire [2:0]  poh_bit_idx_in,
   input  wire        trace_buffer_bit_in,
   input  wire [3:0]  b3_error_count_in,
   input  wire        overhead_serial_input_in,
   input  wire        overhead_insert_enable_input_in,
   input  wire        remote_defect_input_in,
   input  wire        new_data_flag_pattern_input_in,
   output wire [15:0] pointer_word_out,
   output wire [9:0]  timing_pointer_out,
   output wire        overhead_bit_out
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // The pins come from another clock, so each passes two flip-flops.
   // This costs two cycles of latency against the bit strobe.
   wire poh_serial;
   wire poh_enable;
   wire rdi_pin;
   wire flag_pin;

   tpo_sync2 u_sync_serial (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pin_in     (overhead_serial_input_in),
      .pin_out    (poh_serial)
   );

   tpo_sync2 u_sync_enable (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pin_in     (overhead_insert_enable_input_in),
      .pin_out    (poh_enable)
   );

   tpo_sync2 u_sync_defect (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pin_in     (remote_defect_input_in),
      .pin_out    (rdi_pin)
   );

   tpo_sync2 u_sync_flag (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pin_in     (new_data_flag_pattern_input_in),
      .pin_out    (flag_pin)
   );

   // ----------------------------------------------------------------
   // Bus address phase
   // ----------------------------------------------------------------
   reg        wr_pend_r;
   reg [7:0]  wr_idx_r;
   reg        rd_wait_r;
   reg [7:0]  rd_idx_r;
   reg [7:0]  rdata_r;

   wire       take = hsel_in & htrans_in[1] & hready_in;
   wire [7:0] addr_idx = haddr_in[9:2];

   // Reads insert one wait state so a write just ahead is visible.
   assign hreadyout_out = ~rd_wait_r;
   assign hresp_out     = 1'b0;
   // Only the low byte of a word holds a register; the rest reads zero.
   assign hrdata_out    = {24'h0000_00, rdata_r};

   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= 8'h00;
         rd_wait_r <= 1'b0;
         rd_idx_r  <= 8'h00;
      end else begin
         wr_pend_r <= take & hwrite_in;
         rd_wait_r <= take & ~hwrite_in;
         if (take) begin
            wr_idx_r <= addr_idx;
            rd_idx_r <= addr_idx;
         end
      end
   end

   // Writes land at the end of their data phase, when hwdata stands.
   wire [7:0] wd = hwdata_in[7:0];
   wire wr_ptr_ctrl = wr_pend_r & (wr_idx_r == `TPO_IDX_PTR_CTRL);
   wire wr_src_ctrl = wr_pend_r & (wr_idx_r == `TPO_IDX_SRC_CTRL);
   wire wr_frc_lo   = wr_pend_r & (wr_idx_r == `TPO_IDX_FRC_LO);
   wire wr_frc_hi   = wr_pend_r & (wr_idx_r == `TPO_IDX_FRC_HI);
   wire wr_trace    = wr_pend_r & (wr_idx_r == `TPO_IDX_TRACE);
   wire wr_label    = wr_pend_r & (wr_idx_r == `TPO_IDX_LABEL);
   wire wr_status   = wr_pend_r & (wr_idx_r == `TPO_IDX_STATUS);
   wire wr_user     = wr_pend_r & (wr_idx_r == `TPO_IDX_USER);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   reg [7:0] frc_lo_r;
   reg [7:0] frc_hi_r;
   reg [7:0] trace_r;
   reg [7:0] label_r;
   reg [3:0] febe_r;
   reg [3:0] status_lo_r;
   reg [7:0] user_r;
   reg       ftp_r;
   reg       flag_en_r;
   reg       load_req_r;
   reg       inc_req_r;
   reg       dec_req_r;
   reg [1:0] src_r;

   wire [9:0] forced_pointer_value = {frc_hi_r[1:0], frc_lo_r};
   wire [3:0] new_data_flag_pattern = frc_hi_r[7:4];
   wire [1:0] spare_bits = frc_hi_r[3:2];

   // ----------------------------------------------------------------
   // Pointer generator
   // ----------------------------------------------------------------
   reg  [9:0]  current_pointer_r;
   reg  [9:0]  timing_ptr_r;
   reg  [15:0] ptr_word_r;
   reg         febe_done_r;

   // A load outranks a justification in the same frame.
   wire load_now = frame_start_in & load_req_r;
   wire inc_now  = frame_start_in & ~load_req_r & inc_req_r;
   wire dec_now  = frame_start_in & ~load_req_r & ~inc_req_r & dec_req_r;

   reg [9:0] cur_nxt;
   reg [9:0] tim_nxt;

   always @* begin
      cur_nxt = current_pointer_r;
      tim_nxt = timing_ptr_r;
      if (load_now) begin
         cur_nxt = forced_pointer_value;
         // An out-of-range load is sent, but timing keeps the old offset.
         if (forced_pointer_value <= `TPO_PTR_MAX)
            tim_nxt = forced_pointer_value;
      end else if (inc_now) begin
         // Justifications wrap around the valid range of offsets.
         if (current_pointer_r >= `TPO_PTR_MAX)
            cur_nxt = 10'h000;
         else
            cur_nxt = current_pointer_r + 10'h001;
         tim_nxt = cur_nxt;
      end else if (dec_now) begin
         if (current_pointer_r == 10'h000 ||
             current_pointer_r > `TPO_PTR_MAX)
            cur_nxt = `TPO_PTR_MAX;
         else
            cur_nxt = current_pointer_r - 10'h001;
         tim_nxt = cur_nxt;
      end
   end

   // The pin and the enable bit both hold the programmed flag on.
   wire flag_forced = flag_en_r | flag_pin;
   wire [3:0] flag_sel = (load_now | flag_forced) ?
                         new_data_flag_pattern :
                         `TPO_FLAG_NORMAL;
   wire [9:0] ptr_sel  = ftp_r ? forced_pointer_value : cur_nxt;

   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         current_pointer_r <= 10'h000;
         timing_ptr_r      <= 10'h000;
         ptr_word_r        <= {`TPO_FLAG_NORMAL, 12'h000};
      end else begin
         current_pointer_r <= cur_nxt;
         timing_ptr_r      <= tim_nxt;
         // The word is rebuilt only at a frame boundary, held in between.
         if (frame_start_in)
            ptr_word_r <= {flag_sel, spare_bits, ptr_sel};
      end
   end

   assign pointer_word_out   = ptr_word_r;
   assign timing_pointer_out = timing_ptr_r;

   // ----------------------------------------------------------------
   // Control and overhead registers
   // ----------------------------------------------------------------
   // A software write in the same cycle as a self-clear is kept.
   wire febe_clear = poh_bit_strobe_in &
                     (poh_byte_sel_in == `TPO_SEL_G1) &
                     (poh_bit_idx_in == 3'd4) &
                     ~(src_r[`TPO_BIT_SRC_STATUS] | poh_enable);

   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         frc_lo_r    <= 8'h00;
         frc_hi_r    <= `TPO_RST_FRC_HI;
         trace_r     <= 8'h00;
         label_r     <= `TPO_RST_LABEL;
         febe_r      <= 4'h0;
         status_lo_r <= 4'h0;
         user_r      <= 8'h00;
         ftp_r       <= 1'b0;
         flag_en_r   <= 1'b0;
         load_req_r  <= 1'b0;
         inc_req_r   <= 1'b0;
         dec_req_r   <= 1'b0;
         src_r       <= 2'h0;
      end else begin
         if (wr_frc_lo)
            frc_lo_r <= wd;
         if (wr_frc_hi)
            frc_hi_r <= wd;
         if (wr_trace)
            trace_r <= wd;
         if (wr_label)
            label_r <= wd;
         if (wr_user)
            user_r <= wd;
         if (wr_src_ctrl)
            src_r <= wd[1:0];
         if (wr_status) begin
            febe_r      <= wd[7:4];
            status_lo_r <= wd[3:0];
         end else if (febe_clear) begin
            febe_r <= 4'h0;
         end
         if (wr_ptr_ctrl) begin
            ftp_r      <= wd[`TPO_BIT_FTP];
            flag_en_r  <= wd[`TPO_BIT_FLAG_EN];
            load_req_r <= wd[`TPO_BIT_LOAD];
            inc_req_r  <= wd[`TPO_BIT_INC];
            dec_req_r  <= wd[`TPO_BIT_DEC];
         end else begin
            if (load_now)
               load_req_r <= 1'b0;
            if (inc_now)
               inc_req_r <= 1'b0;
            if (dec_now)
               dec_req_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Path overhead bit insertion
   // ----------------------------------------------------------------
   wire status_from_port = src_r[`TPO_BIT_SRC_STATUS] | poh_enable;
   // A non-zero software count beats the count derived from B3 errors.
   wire [3:0] febe_val   = (febe_r != 4'h0) ? febe_r :
                           b3_error_count_in;
   wire [7:0] status_byte = {febe_val,
                             status_lo_r[3] | rdi_pin,
                             status_lo_r[2],
                             status_lo_r[1:0]};

   reg oh_bit_r;
   reg oh_nxt;

   always @* begin
      // Without a strobe the last bit is held for the outgoing stream.
      oh_nxt = oh_bit_r;
      if (poh_bit_strobe_in) begin
         case (poh_byte_sel_in)
            `TPO_SEL_J1: begin
               // The serial port outranks the trace buffer.
               if (poh_enable)
                  oh_nxt = poh_serial;
               else if (src_r[`TPO_BIT_SRC_TRACE])
                  oh_nxt = trace_buffer_bit_in;
               else
                  oh_nxt = trace_r[poh_bit_idx_in];
            end
            `TPO_SEL_C2: begin
               oh_nxt = poh_enable ? poh_serial :
                        label_r[poh_bit_idx_in];
            end
            `TPO_SEL_G1: begin
               oh_nxt = status_from_port ? poh_serial :
                        status_byte[poh_bit_idx_in];
            end
            default: begin
               oh_nxt = poh_enable ? poh_serial :
                        user_r[poh_bit_idx_in];
            end
         endcase
      end
   end

   always @(posedge sys_clk_in) begin
      if (reset_in)
         oh_bit_r <= 1'b0;
      else
         oh_bit_r <= oh_nxt;
   end

   assign overhead_bit_out = oh_bit_r;

   // ----------------------------------------------------------------
   // Read-back
   // ----------------------------------------------------------------
   reg [7:0] rd_nxt;

   always @* begin
      // Pointer halves are read live, so software must re-read them.
      case (rd_idx_r)
         `TPO_IDX_CUR_LO:   rd_nxt = current_pointer_r[7:0];
         `TPO_IDX_CUR_HI:   rd_nxt = {6'h00, current_pointer_r[9:8]};
         `TPO_IDX_FRC_LO:   rd_nxt = frc_lo_r;
         `TPO_IDX_FRC_HI:   rd_nxt = frc_hi_r;
         `TPO_IDX_TRACE:    rd_nxt = trace_r;
         `TPO_IDX_LABEL:    rd_nxt = label_r;
         `TPO_IDX_STATUS:   rd_nxt = {febe_r, status_lo_r};
         `TPO_IDX_USER:     rd_nxt = user_r;
         `TPO_IDX_PTR_CTRL: rd_nxt = {1'b0, ftp_r, 1'b0, load_req_r, flag_en_r,
                                      dec_req_r, inc_req_r, 1'b0};
         `TPO_IDX_SRC_CTRL: rd_nxt = {6'h00, src_r};
         default:           rd_nxt = 8'h00;
      endcase
   end

   always @(posedge sys_clk_in) begin
      if (reset_in)
         rdata_r <= 8'h00;
      else if (rd_wait_r)
         rdata_r <= rd_nxt;
   end

endmodule

// ----------------------------------------------------------------
// Two-flop pin synchroniser
// ----------------------------------------------------------------
module tpo_sync2 (
   input  wire sys_clk_in,
   input  wire reset_in,
   input  wire pin_in,
   output wire pin_out
);

   // Only the second flip-flop feeds logic; the first may go metastable.
   reg meta_r;
   reg sync_r;

   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   assign pin_out = sync_r;

endmodule

/* File: verification/tpo_regs_properties.sv */
`timescale 1ns/1ps
module tpo_regs_properties (
   input wire        sys_clk_in,
   input wire        reset_in,
   input wire        hsel_in,
   input wire        hwrite_in,
   input wire        hready_in,
   input wire [1:0]  htrans_in,
   input wire [31:0] hrdata_out,
   input wire        hreadyout_out,
   input wire        hresp_out,
   input wire        frame_start_in,
   input wire        poh_bit_strobe_in,
   input wire [15:0] pointer_word_out,
   input wire [9:0]  timing_pointer_out,
   input wire        overhead_bit_out
);
   // ----------------------------------------
   // Bus and stream relations
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   wire take = hsel_in & htrans_in[1] & hready_in;
   sequence rd_phase;
      !hreadyout_out ##1 hreadyout_out;
   endsequence
   chk_read_wait: assert property (take && !hwrite_in |=> rd_phase)
      else $error("Read data phase is not two cycles.");
   chk_write_nowait: assert property (
      take && hwrite_in |=> hreadyout_out)
      else $error("Write data phase stalled.");
   chk_resp_okay: assert property (!hresp_out)
      else $error("Response is not okay.");
   chk_rdata_upper: assert property (hrdata_out[31:8] == 24'h00_0000)
      else $error("Read data upper bits not zero.");
   // A pointer may only move at a frame boundary, or the far end loses it.
   chk_ptr_frame: assert property (
      !frame_start_in |=> $stable(pointer_word_out))
      else $error("Pointer word moved between frames.");
   chk_timing_range: assert property (timing_pointer_out <= 10'h30e)
      else $error("Timing pointer out of range.");
   chk_timing_frame: assert property (
      !frame_start_in |=> $stable(timing_pointer_out))
      else $error("Timing pointer moved between frames.");
   chk_obit_hold: assert property (
      !poh_bit_strobe_in |=> $stable(overhead_bit_out))
      else $error("Overhead bit changed without strobe.");
endmodule

bind tpo_regs tpo_regs_properties u_chk (.sys_clk_in, .reset_in, .hsel_in,
   .hwrite_in, .hready_in, .htrans_in, .hrdata_out, .hreadyout_out,
   .hresp_out, .frame_start_in, .poh_bit_strobe_in, .pointer_word_out,
   .timing_pointer_out, .overhead_bit_out);

/* File: verification/tpo_regs_test.sv */
`timescale 1ns/1ps
`include "tpo_map.vh"
module tpo_regs_test;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   logic sys_clk_in = 0, reset_in = 1, hsel_in = 0, hwrite_in = 0;
   logic [31:0] haddr_in = '0, hwdata_in = '0, rd;
   logic [1:0]  htrans_in = '0, poh_byte_sel_in = '0;
   logic [2:0]  hsize_in = 3'h2, poh_bit_idx_in = '0;
   logic        frame_start_in = 0, poh_bit_strobe_in = 0;
   logic        trace_buffer_bit_in = 0, overhead_serial_input_in = 0;
   logic        overhead_insert_enable_input_in = 0;
   logic        remote_defect_input_in = 0;
   logic        new_data_flag_pattern_input_in = 0;
   logic [3:0]  b3_error_count_in = 4'h3;
   wire  [31:0] hrdata_out;
   wire         hreadyout_out, hresp_out, overhead_bit_out;
   wire  [15:0] pointer_word_out;
   wire  [9:0]  timing_pointer_out;
   int          num_errors = 0, num_checks = 0;

   always #50 sys_clk_in = ~sys_clk_in;

   tpo_regs u_dut (.sys_clk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out),
      .hrdata_out, .hreadyout_out, .hresp_out, .frame_start_in,
      .poh_bit_strobe_in, .poh_byte_sel_in, .poh_bit_idx_in,
      .trace_buffer_bit_in, .b3_error_count_in, .overhead_serial_input_in,
      .overhead_insert_enable_input_in, .remote_defect_input_in,
      .new_data_flag_pattern_input_in, .pointer_word_out,
      .timing_pointer_out, .overhead_bit_out);

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // The master never assumes a latency; the watchdog ends a hung wait.
   task wait_rdy;
      @(posedge sys_clk_in);
      while (hreadyout_out !== 1'b1)
         @(posedge sys_clk_in);
   endtask

   task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      hsel_in   <= 1;
      haddr_in  <= {22'h00_0000, idx, 2'b00};
      htrans_in <= 2'b10;
      hwrite_in <= w;
      wait_rdy;
      hsel_in   <= 0;
      htrans_in <= 2'b00;
      hwdata_in <= wd;
      wait_rdy;
      rd = hrdata_out;
   endtask

   task wr(input logic [7:0] idx, input logic [31:0] wd);
      bus(1, idx, wd);
   endtask

   task rdc(input logic [7:0] idx, input logic [31:0] exp);
      bus(0, idx, '0);
      chk(rd, exp);
   endtask

   task frame;
      repeat (3) @(posedge sys_clk_in);
      frame_start_in <= 1;
      @(posedge sys_clk_in);
      frame_start_in <= 0;
      @(posedge sys_clk_in);
   endtask

   task obit(input logic [1:0] s, input logic [2:0] i, input logic e);
      poh_byte_sel_in   <= s;
      poh_bit_idx_in    <= i;
      poh_bit_strobe_in <= 1;
      @(posedge sys_clk_in);
      poh_bit_strobe_in <= 0;
      @(posedge sys_clk_in);
      chk({31'h0, overhead_bit_out}, {31'h0, e});
   endtask

   task pins(input logic en, input logic rdi, input logic nf);
      overhead_insert_enable_input_in <= en;
      remote_defect_input_in          <= rdi;
      new_data_flag_pattern_input_in  <= nf;
      repeat (4) @(posedge sys_clk_in);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      rdc(`TPO_IDX_CUR_LO, '0);
      rdc(`TPO_IDX_FRC_LO, '0);
      rdc(`TPO_IDX_FRC_HI, 32'h0000_0090);
      rdc(`TPO_IDX_LABEL, 32'h0000_0013);
      chk(pointer_word_out, 32'h0000_6000);
      wr(`TPO_IDX_CUR_LO, 32'h0000_00ff);
      rdc(`TPO_IDX_CUR_LO, '0);
      rdc(8'h7f, '0);
      $display("test reset done");
   endtask

   task t_load;
      wr(`TPO_IDX_FRC_LO, 32'h0000_000a);
      wr(`TPO_IDX_FRC_HI, 32'h0000_0099);
      wr(`TPO_IDX_PTR_CTRL, 32'h0000_0010);
      frame;
      chk(pointer_word_out, 32'h0000_990a);
      chk(timing_pointer_out, 32'h0000_010a);
      rdc(`TPO_IDX_CUR_LO, 32'h0000_000a);
      rdc(`TPO_IDX_CUR_HI, 32'h0000_0001);
      rdc(`TPO_IDX_PTR_CTRL, '0);
      frame;
      chk(pointer_word_out, 32'h0000_690a);
      $display("test load done");
   endtask

   task t_just;
      wr(`TPO_IDX_PTR_CTRL, 32'h0000_0002);
      frame;
      rdc(`TPO_IDX_CUR_LO, 32'h0000_000b);
      rdc(`TPO_IDX_CUR_LO, 32'h0000_000b);
      wr(`TPO_IDX_PTR_CTRL, 32'h0000_0004);
      frame;
      rdc(`TPO_IDX_CUR_LO, 32'h0000_000a);
      $display("test justify done");
   endtask

   task t_force;
      wr(`TPO_IDX_FRC_LO, 32'h0000_00ff);
      wr(`TPO_IDX_FRC_HI, 32'h0000_0063);
      wr(`TPO_IDX_PTR_CTRL, 32'h0000_0010);
      frame;
      chk(pointer_word_out, 32'h0000_63ff);
      chk(timing_pointer_out, 32'h0000_010a);
      wr(`TPO_IDX_FRC_LO, 32'h0000_0055);
      wr(`TPO_IDX_FRC_HI, 32'h0000_0090);
      wr(`TPO_IDX_PTR_CTRL, 32'h0000_0048);
      frame;
      chk(pointer_word_out, 32'h0000_9055);
      rdc(`TPO_IDX_CUR_LO, 32'h0000_00ff);
      wr(`TPO_IDX_PTR_CTRL, '0);
      pins(0, 0, 1);
      frame;
      chk(pointer_word_out, 32'h0000_93ff);
      pins(0, 0, 0);
      $display("test force done");
   endtask

   task t_oh;
      wr(`TPO_IDX_TRACE, 32'h0000_00a5);
      obit(`TPO_SEL_J1, 3'h7, 1);
      obit(`TPO_SEL_J1, 3'h6, 0);
      wr(`TPO_IDX_SRC_CTRL, 32'h0000_0002);
      trace_buffer_bit_in <= 1;
      obit(`TPO_SEL_J1, 3'h6, 1);
      wr(`TPO_IDX_SRC_CTRL, '0);
      obit(`TPO_SEL_C2, 3'h4, 1);
      wr(`TPO_IDX_USER, 32'h0000_0080);
      obit(`TPO_SEL_F2, 3'h7, 1);
      pins(1, 0, 0);
      obit(`TPO_SEL_F2, 3'h7, 0);
      overhead_serial_input_in <= 1;
      repeat (4) @(posedge sys_clk_in);
      obit(`TPO_SEL_C2, 3'h7, 1);
      obit(`TPO_SEL_J1, 3'h6, 1);
      overhead_serial_input_in <= 0;
      pins(0, 0, 0);
      wr(`TPO_IDX_STATUS, 32'h0000_005f);
      rdc(`TPO_IDX_STATUS, 32'h0000_005f);
      obit(`TPO_SEL_G1, 3'h6, 1);
      obit(`TPO_SEL_G1, 3'h5, 0);
      obit(`TPO_SEL_G1, 3'h4, 1);
      rdc(`TPO_IDX_STATUS, 32'h0000_000f);
      obit(`TPO_SEL_G1, 3'h5, 1);
      obit(`TPO_SEL_G1, 3'h3, 1);
      obit(`TPO_SEL_G1, 3'h2, 1);
      obit(`TPO_SEL_G1, 3'h0, 1);
      wr(`TPO_IDX_STATUS, '0);
      pins(0, 1, 0);
      obit(`TPO_SEL_G1, 3'h3, 1);
      obit(`TPO_SEL_G1, 3'h2, 0);
      wr(`TPO_IDX_SRC_CTRL, 32'h0000_0001);
      obit(`TPO_SEL_G1, 3'h3, 0);
      wr(`TPO_IDX_SRC_CTRL, '0);
      wr(`TPO_IDX_STATUS, 32'h0000_0007);
      pins(1, 0, 0);
      obit(`TPO_SEL_G1, 3'h2, 0);
      obit(`TPO_SEL_G1, 3'h1, 0);
      $display("test overhead done");
   endtask

   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles; this allows ample slack.
   initial begin
      #500_000;
      num_errors++;
      tally_and_finish;
   end

   initial begin
      repeat (3) @(posedge sys_clk_in);
      reset_in <= 0;
      @(posedge sys_clk_in);
      t_reset;
      t_load;
      t_just;
      t_force;
      t_oh;
      tally_and_finish;
   end
endmodule
